// ---- msm_params.svh ----
// Constants for the multidrop scan chain multiplexer
// Summary of operation
// - Device becomes selected only when the scanned address matches its slot inputs, is the broadcast address or a group matching the low two slot bits.
// - Decoder knows 249 slots, interrogation, broadcast and four groups; zero is reserved.
// - Park instruction holds the local TAPs in a stable state.
// - A 32-bit test clock counter lets self-test run beside other scans.
// - Backplane port and local port zero are interchangeable bidirectional ports.
// - Backplane test reset of the master port may be disregarded for the local resets.
// - Mode register bypasses or inserts local ports singly or in groups.
// - One instruction enables transparent mode straight to one local port.
// - A 16-bit LFSR compacts scan data returned from local chains.
// - Output-enable input floats local outputs; ports zero to three flag it.
// - A 16-state TAP controller drives standard capture, shift and update.
// - Device reset input forces the whole device into reset at once.
// - Address mask input ignores the low slot bits in the comparison.
// - Master select 0 picks port B0 as master, else B1; other is port zero.
// - Stitch strap skips selection protocols; port include inputs pick the ports.
// - Transparent strap is copied into the transparent enable bit after reset.
// - Idle local TAPs drive local reset from two strap levels.
// - Device reset or ungated backplane reset drives every local reset low.
// - Backplane TDO returns device and local chain data to the master.
// - All scan activity is clocked by the master backplane test clock only.
// - Backplane test reset clears the test logic on the third mclk edge after the pin falls, without waiting for a test clock.
// - Backplane TMS steps both the device TAP and the selected local TAPs.
// - Notification output is high whenever its TDO output floats.
// - Pass-through bits connect only when exactly one local port is selected.
// - Output-enable input high floats every local scan port output.
// - Local TCK copies backplane TCK; local resets gate backplane reset.
`ifndef MSM_PARAMS_SVH
`define MSM_PARAMS_SVH
`define MSM_SYNC_W 43
`define MSM_ADDR_RSVD 8'h00
`define MSM_ADDR_BCAST 8'hFF
`define MSM_ADDR_INTG 8'hFE
`define MSM_GRP_TOP 6'h3E
`define MSM_CARE_ALL 8'hFF
`define MSM_CARE_MASKED 8'hFC
`define MSM_IR_CAP 8'h01
`define MSM_OP_BYPASS 8'hFF
`define MSM_OP_UNSEL 8'h01
`define MSM_OP_PARK 8'h02
`define MSM_OP_UNPARK 8'h03
`define MSM_OP_MODE0 8'h04
`define MSM_OP_CNT 8'h05
`define MSM_OP_SIG 8'h06
`define MSM_OP_PASSTHROUGH_STRAP 8'h07
`define MSM_M0_RST 9'h000
`define MSM_M0_SIG 7
`define MSM_M0_CNT 8
`define MSM_TOP_MODE0 5'h08
`define MSM_TOP_CNT 5'h1F
`define MSM_TOP_SIG 5'h0F
`define MSM_SIG_POLY 16'h1021
`endif

// ---- msm_pkg.sv ----
// Types shared by the scan chain multiplexer
package msm_pkg;
  typedef enum logic [3:0] {
    st_tlr, st_rti, st_seldr, st_capdr, st_shdr, st_ex1dr, st_psdr, st_ex2dr,
    st_updr, st_selir, st_capir, st_shir, st_ex1ir, st_psir, st_ex2ir, st_upir
  } msm_tap_t;
endpackage

// ---- msm_tap.sv ----
// Sixteen-state test access port controller
`timescale 1ns/1ns
module msm_tap (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic tst_clr, // Test reset level
  input wire logic tck_rise, // Test clock rising edge
  input wire logic tms, // Mode select
  output msm_pkg::msm_tap_t state_ff // Current state
);
  function automatic msm_pkg::msm_tap_t step(input msm_pkg::msm_tap_t s, input logic t);
    unique case (s)
      msm_pkg::st_tlr: step = t ? msm_pkg::st_tlr : msm_pkg::st_rti;
      msm_pkg::st_rti: step = t ? msm_pkg::st_seldr : msm_pkg::st_rti;
      msm_pkg::st_seldr: step = t ? msm_pkg::st_selir : msm_pkg::st_capdr;
      msm_pkg::st_capdr: step = t ? msm_pkg::st_ex1dr : msm_pkg::st_shdr;
      msm_pkg::st_shdr: step = t ? msm_pkg::st_ex1dr : msm_pkg::st_shdr;
      msm_pkg::st_ex1dr: step = t ? msm_pkg::st_updr : msm_pkg::st_psdr;
      msm_pkg::st_psdr: step = t ? msm_pkg::st_ex2dr : msm_pkg::st_psdr;
      msm_pkg::st_ex2dr: step = t ? msm_pkg::st_updr : msm_pkg::st_shdr;
      msm_pkg::st_updr: step = t ? msm_pkg::st_seldr : msm_pkg::st_rti;
      msm_pkg::st_selir: step = t ? msm_pkg::st_tlr : msm_pkg::st_capir;
      msm_pkg::st_capir: step = t ? msm_pkg::st_ex1ir : msm_pkg::st_shir;
      msm_pkg::st_shir: step = t ? msm_pkg::st_ex1ir : msm_pkg::st_shir;
      msm_pkg::st_ex1ir: step = t ? msm_pkg::st_upir : msm_pkg::st_psir;
      msm_pkg::st_psir: step = t ? msm_pkg::st_ex2ir : msm_pkg::st_psir;
      msm_pkg::st_ex2ir: step = t ? msm_pkg::st_upir : msm_pkg::st_shir;
      msm_pkg::st_upir: step = t ? msm_pkg::st_seldr : msm_pkg::st_rti;
    endcase
  endfunction

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      state_ff <= msm_pkg::st_tlr;
    else if (tst_clr)
      state_ff <= msm_pkg::st_tlr;
    else if (tck_rise)
      state_ff <= step(state_ff, tms);
  end
endmodule // msm_tap

// ---- msm_mux.sv ----
// Addressable multidrop scan chain multiplexer, seven local ports
`timescale 1ns/1ns
`include "msm_params.svh"
module msm_mux (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Device reset, high
  input wire logic [1:0] bp_tck_in, // B1/B0 TCK pin level
  output logic [1:0] bp_tck_out, // TCK drive, slave side
  output logic [1:0] bp_tck_oe, // TCK enable
  input wire logic [1:0] bp_tms_in, // TMS pin level
  output logic [1:0] bp_tms_out, // TMS drive
  output logic [1:0] bp_tms_oe, // TMS enable
  input wire logic [1:0] bp_tdi_in, // TDI pins
  output logic [1:0] bp_tdo_out, // TDO drive
  output logic [1:0] bp_tdo_oe, // TDO enable
  input wire logic [1:0] bp_trst_n_in, // Test reset pin level
  output logic [1:0] bp_trst_n_out, // Test reset drive
  output logic [1:0] bp_trst_oe, // Test reset enable
  input wire logic [3:0] bp_pass_a, // Pass inputs, [3:2] B1
  output logic [3:0] bp_pass_y, // Pass outputs
  output logic [1:0] bp_pass_y_oe, // Pass enables per port
  output logic [5:0] lp_tck_out, // Local ports 1..6 TCK
  output logic [5:0] lp_tms_out, // Local TMS
  output logic [5:0] lp_tdo_out, // Local TDO, to chain
  input wire logic [5:0] lp_tdi_in, // Local TDI, from chain
  output logic [5:0] lp_trst_n_out, // Local test resets
  output logic [5:0] lp_oe, // Local output enables
  input wire logic [1:0] lp1_pass_a, // Port 1 pass inputs
  output logic [1:0] lp1_pass_y, // Port 1 pass outputs
  output logic lp1_pass_y_oe, // Port 1 pass enable
  output logic [4:0] hiz_notify_out, // Float flags: B0,B1,ports 1..3
  input wire logic [7:0] slot_id, // Slot identification
  input wire logic slot_address_mask_in, // Ignore low slot bits
  input wire logic master_port_select, // 0: B0 master
  input wire logic addressed_or_stitch_select, // 1: stitching
  input wire logic [6:0] stitch_port_include, // Ports in stitch chain
  input wire logic passthrough_strap, // Transparent strap
  input wire logic idle_local_reset_level, // Idle reset, ports 0..5
  input wire logic idle_local_reset_level_port6, // Idle reset, port 6
  input wire logic backplane_reset_disregard, // Ignore master reset
  input wire logic local_oe_n // Local output enable, low
);
  logic [`MSM_SYNC_W-1:0] sync1_ff, sync_ff;
  logic [1:0] s_tck, s_tms, s_tdi, s_trst_n, s_lpa;
  logic [5:0] s_lp_tdi;
  logic [7:0] s_slot;
  logic s_mask, s_mps, s_stitch, s_pstrap, s_idle, s_idle6, s_disreg, s_oe_n;
  logic [6:0] s_incl;
  logic [3:0] s_pa;
  logic m_tck, m_tms, m_tdi, m_trst_n, tst_clr, tck_d_ff, rise, fall;
  msm_pkg::msm_tap_t st;
  logic [1:0] boot_ff;
  logic ptbit_ff, sel_ff, intg_ff, act;
  logic [7:0] ir_sh_ff, ir_ff;
  logic [8:0] mode0_ff;
  logic passthrough_strap_ff, unpk_ff, req_ff, ptlr_ff;
  logic [31:0] cnt_ff, dr_sh_ff, dr_cap;
  logic [15:0] sig_ff;
  logic dev_tdo_ff, transparent, unpk, lcl_tlr, chain_out, one, oe_l, mdrv, pen;
  logic [6:0] incl, eff, tsel, path, nxt_lp_tdo, nxt_tms, nxt_trst, idle_v;
  logic [1:0] nxt_tdo_oe, ma, sa, pret;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] slot,
    input logic msk);
    logic [7:0] care;
    care = msk ? `MSM_CARE_MASKED : `MSM_CARE_ALL;
    if (a == `MSM_ADDR_BCAST)
      addr_hit = 1'b1;
    else if (a[7:2] == `MSM_GRP_TOP)
      addr_hit = (a[1:0] == slot[1:0]);
    else if (a == `MSM_ADDR_RSVD || a == `MSM_ADDR_INTG)
      addr_hit = 1'b0;
    else
      addr_hit = ((a ^ slot) & care) == 8'h00;
  endfunction

  // Bit at index mp goes to the master pin, the other to the slave pin
  function automatic logic [1:0] pair(input logic mp, input logic mv, input logic sv);
    pair = mp ? {mv, sv} : {sv, mv};
  endfunction

  function automatic logic [31:0] shr(input logic [31:0] v, input logic b,
    input logic [4:0] top);
    shr = v >> 1;
    shr[top] = b;
  endfunction

  // Every pin and strap is asynchronous to mclk
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      sync1_ff <= {bp_tck_in, bp_tms_in, bp_tdi_in, bp_trst_n_in, lp_tdi_in, slot_id,
        slot_address_mask_in, master_port_select, addressed_or_stitch_select,
        stitch_port_include, passthrough_strap, idle_local_reset_level,
        idle_local_reset_level_port6, backplane_reset_disregard, local_oe_n,
        bp_pass_a, lp1_pass_a};
      sync_ff <= sync1_ff;
    end
  end

  assign {s_tck, s_tms, s_tdi, s_trst_n, s_lp_tdi, s_slot, s_mask, s_mps, s_stitch,
    s_incl, s_pstrap, s_idle, s_idle6, s_disreg, s_oe_n, s_pa, s_lpa} = sync_ff;

  assign m_tck = s_tck[s_mps];
  assign m_tms = s_tms[s_mps];
  assign m_tdi = s_tdi[s_mps];
  assign m_trst_n = s_trst_n[s_mps];
  // Level acts on the next mclk edge, no TCK needed
  assign tst_clr = ~m_trst_n;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      tck_d_ff <= 1'b0;
    else
      tck_d_ff <= m_tck;
  end

  // Sync stage reads zero after release, so a TCK pin idling high would fake a rise
  assign rise = m_tck & ~tck_d_ff & (boot_ff == 2'h3);
  assign fall = ~m_tck & tck_d_ff;

  msm_tap u_tap (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tst_clr(tst_clr),
    .tck_rise(rise),
    .tms(m_tms),
    .state_ff(st)
  );

  // Sync stage holds zero for two cycles after release, so wait before latching
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      boot_ff <= 2'h0;
      ptbit_ff <= 1'b0;
    end
    else if (boot_ff != 2'h3)
    begin
      boot_ff <= boot_ff + 2'h1;
      if (boot_ff == 2'h2)
        ptbit_ff <= s_pstrap;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_ff <= 1'b0;
      intg_ff <= 1'b0;
    end
    else if (tst_clr || st == msm_pkg::st_tlr)
    begin
      sel_ff <= 1'b0;
      intg_ff <= 1'b0;
    end
    else if (fall && st == msm_pkg::st_upir)
    begin
      if (!sel_ff)
      begin
        sel_ff <= addr_hit(ir_sh_ff, s_slot, s_mask);
        intg_ff <= (ir_sh_ff == `MSM_ADDR_INTG);
      end
      else
      begin
        intg_ff <= 1'b0;
        if (ir_sh_ff == `MSM_OP_UNSEL)
          sel_ff <= 1'b0;
      end
    end
  end

  assign act = s_stitch | sel_ff;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ir_sh_ff <= 8'h00;
      ir_ff <= `MSM_OP_BYPASS;
    end
    else if (tst_clr)
    begin
      ir_sh_ff <= 8'h00;
      ir_ff <= `MSM_OP_BYPASS;
    end
    else
    begin
      if (rise && st == msm_pkg::st_capir)
        ir_sh_ff <= intg_ff ? s_slot : `MSM_IR_CAP;
      else if (rise && st == msm_pkg::st_shir)
        ir_sh_ff <= {m_tdi, ir_sh_ff[7:1]};
      if (fall && st == msm_pkg::st_upir && act)
        ir_ff <= ir_sh_ff;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode0_ff <= `MSM_M0_RST;
      passthrough_strap_ff <= 1'b0;
      unpk_ff <= 1'b0;
      req_ff <= 1'b0;
      ptlr_ff <= 1'b1;
    end
    else if (tst_clr)
    begin
      mode0_ff <= `MSM_M0_RST;
      passthrough_strap_ff <= 1'b0;
      unpk_ff <= 1'b0;
      req_ff <= 1'b0;
      ptlr_ff <= 1'b1;
    end
    else if (st == msm_pkg::st_tlr)
    begin
      unpk_ff <= 1'b0;
      req_ff <= 1'b0;
      ptlr_ff <= 1'b1;
    end
    else
    begin
      if (fall && st == msm_pkg::st_upir && sel_ff)
      begin
        if (ir_sh_ff == `MSM_OP_PARK)
          req_ff <= 1'b0;
        if (ir_sh_ff == `MSM_OP_UNPARK)
          req_ff <= 1'b1;
        if (ir_sh_ff == `MSM_OP_PASSTHROUGH_STRAP)
          passthrough_strap_ff <= 1'b1;
      end
      if (fall && st == msm_pkg::st_updr && act && ir_ff == `MSM_OP_MODE0)
        mode0_ff <= dr_sh_ff[8:0];
      // Change only in Run-Test/Idle, so locals stop in a stable state
      if (rise && st == msm_pkg::st_rti && unpk_ff != req_ff)
      begin
        unpk_ff <= req_ff;
        ptlr_ff <= 1'b0;
      end
    end
  end

  always_comb
  begin
    unique case (ir_ff)
      `MSM_OP_MODE0: dr_cap = {23'h0, mode0_ff};
      `MSM_OP_CNT: dr_cap = cnt_ff;
      `MSM_OP_SIG: dr_cap = {16'h0000, sig_ff};
      default: dr_cap = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      dr_sh_ff <= 32'h0000_0000;
    else if (rise && st == msm_pkg::st_capdr)
      dr_sh_ff <= dr_cap;
    else if (rise && st == msm_pkg::st_shdr)
    begin
      unique case (ir_ff)
        `MSM_OP_MODE0: dr_sh_ff <= shr(dr_sh_ff, m_tdi, `MSM_TOP_MODE0);
        `MSM_OP_CNT: dr_sh_ff <= shr(dr_sh_ff, m_tdi, `MSM_TOP_CNT);
        `MSM_OP_SIG: dr_sh_ff <= shr(dr_sh_ff, m_tdi, `MSM_TOP_SIG);
        default: dr_sh_ff <= shr(dr_sh_ff, m_tdi, 5'h00);
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_ff <= 32'h0000_0000;
    else if (tst_clr)
      cnt_ff <= 32'h0000_0000;
    else if (fall && st == msm_pkg::st_updr && act && ir_ff == `MSM_OP_CNT)
      cnt_ff <= dr_sh_ff;
    else if (rise && mode0_ff[`MSM_M0_CNT])
      cnt_ff <= cnt_ff + 32'h0000_0001;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      sig_ff <= 16'h0000;
    else if (tst_clr)
      sig_ff <= 16'h0000;
    else if (rise && st == msm_pkg::st_shdr && mode0_ff[`MSM_M0_SIG])
      sig_ff <= {sig_ff[14:0], 1'b0} ^
        ((sig_ff[15] ^ chain_out) ? `MSM_SIG_POLY : 16'h0000);
  end

  // Own register output changes on the falling edge, as the chain expects
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      dev_tdo_ff <= 1'b0;
    else if (fall)
      dev_tdo_ff <= (st == msm_pkg::st_shir) ? ir_sh_ff[0] : dr_sh_ff[0];
  end

  assign transparent = act & (s_stitch ? ptbit_ff : passthrough_strap_ff);
  assign incl = s_stitch ? s_incl : mode0_ff[6:0];
  assign unpk = s_stitch | unpk_ff;
  assign eff = unpk ? incl : 7'h00;
  assign tsel = incl & (~incl + 7'h01);
  assign path = transparent ? tsel : eff;
  assign lcl_tlr = unpk ? (st == msm_pkg::st_tlr) : ptlr_ff;
  assign one = (path != 7'h00) && ((path & (path - 7'h01)) == 7'h00);
  assign oe_l = ~s_oe_n;

  // Device register first, then included ports in ascending order
  always_comb
  begin
    chain_out = transparent ? m_tdi : dev_tdo_ff;
    for (int i = 0; i < 7; i++)
    begin
      nxt_lp_tdo[i] = chain_out;
      nxt_tms[i] = path[i] ? m_tms : ptlr_ff;
      if (path[i])
        chain_out = (i == 0) ? s_tdi[~s_mps] : s_lp_tdi[i-1];
    end
  end

  assign idle_v = {s_idle6, {6{s_idle}}};
  assign nxt_trst = (tst_clr && !s_disreg) ? 7'h00 :
    (lcl_tlr ? idle_v : 7'h7F);
  assign mdrv = transparent ||
    ((act || intg_ff) && (st == msm_pkg::st_shir || st == msm_pkg::st_shdr));
  assign nxt_tdo_oe = pair(s_mps, mdrv, oe_l);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lp_tck_out <= 6'h00;
      lp_tms_out <= 6'h00;
      lp_tdo_out <= 6'h00;
      lp_trst_n_out <= 6'h00;
      lp_oe <= 6'h00;
    end
    else
    begin
      lp_tck_out <= {6{m_tck}};
      lp_tms_out <= nxt_tms[6:1];
      lp_tdo_out <= nxt_lp_tdo[6:1];
      lp_trst_n_out <= nxt_trst[6:1];
      lp_oe <= {6{oe_l}};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bp_tck_out <= 2'h0;
      bp_tck_oe <= 2'h0;
      bp_tms_out <= 2'h0;
      bp_tms_oe <= 2'h0;
      bp_trst_n_out <= 2'h0;
      bp_trst_oe <= 2'h0;
      bp_tdo_out <= 2'h0;
      bp_tdo_oe <= 2'h0;
      hiz_notify_out <= 5'h1F;
    end
    else
    begin
      bp_tck_out <= pair(s_mps, 1'b0, m_tck);
      bp_tck_oe <= pair(s_mps, 1'b0, oe_l);
      bp_tms_out <= pair(s_mps, 1'b0, nxt_tms[0]);
      bp_tms_oe <= pair(s_mps, 1'b0, oe_l);
      bp_trst_n_out <= pair(s_mps, 1'b0, nxt_trst[0]);
      bp_trst_oe <= pair(s_mps, 1'b0, oe_l);
      bp_tdo_out <= pair(s_mps, chain_out, nxt_lp_tdo[0]);
      bp_tdo_oe <= nxt_tdo_oe;
      hiz_notify_out <= ~{{3{oe_l}}, nxt_tdo_oe};
    end
  end

  assign ma = s_mps ? s_pa[3:2] : s_pa[1:0];
  assign sa = s_mps ? s_pa[1:0] : s_pa[3:2];
  assign pret = path[0] ? sa : s_lpa;
  assign pen = one && (path[1:0] != 2'h0);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bp_pass_y <= 4'h0;
      bp_pass_y_oe <= 2'h0;
      lp1_pass_y <= 2'h0;
      lp1_pass_y_oe <= 1'b0;
    end
    else
    begin
      bp_pass_y <= s_mps ? {pret, ma} : {ma, pret};
      bp_pass_y_oe <= pair(s_mps, pen, pen && path[0] && oe_l);
      lp1_pass_y <= ma;
      lp1_pass_y_oe <= pen && path[1] && oe_l;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_park_taken;
    rise && st == msm_pkg::st_rti && unpk_ff && !req_ff && !s_stitch && m_trst_n;
  endsequence

  sequence s_parked_low;
    (!unpk_ff && !ptlr_ff) ##1 (lp_tms_out == 6'h00 || transparent);
  endsequence

  a_sel_on_match: assert property ($rose(sel_ff) |->
    $past(fall && st == msm_pkg::st_upir && addr_hit(ir_sh_ff, s_slot, s_mask)))
    else $error("selected without matching address");
  a_trst_gated: assert property ((tst_clr && !s_disreg) |=> lp_trst_n_out == 6'h00)
    else $error("local reset not driven low");
  a_idle_level: assert property ((m_trst_n && lcl_tlr) |=>
    lp_trst_n_out[5] == $past(s_idle6) && lp_trst_n_out[4:0] == {5{$past(s_idle)}})
    else $error("idle local reset level wrong");
  a_local_float: assert property (s_oe_n |=> lp_oe == 6'h00 && hiz_notify_out[4:2] == 3'h7)
    else $error("local outputs not floated");
  a_notify_tdo: assert property (hiz_notify_out[1:0] == ~bp_tdo_oe)
    else $error("notify does not match TDO float");
  a_tdo_quiet: assert property ((!act && !intg_ff) |=> bp_tdo_oe[$past(s_mps)] == 1'b0)
    else $error("unselected device drives TDO");
  a_tck_copy: assert property (rise |=> lp_tck_out == 6'h3F ##1 lp_tck_out == 6'h3F)
    else $error("local TCK does not follow");
  a_cnt_step: assert property ((rise && mode0_ff[`MSM_M0_CNT] && !tst_clr) |=>
    cnt_ff == $past(cnt_ff) + 32'h0000_0001)
    else $error("counter missed a test clock");
  a_park_hold: assert property (s_park_taken |=> s_parked_low)
    else $error("parked locals not held");
  a_tap_reset: assert property (tst_clr |=> st == msm_pkg::st_tlr)
    else $error("test reset did not reach TLR");
endmodule // msm_mux

// ---- msm_chain_model.sv ----
// Behavioural model of the six local scan chains
`timescale 1ns/1ns
module msm_chain_model (
  input wire logic [5:0] lp_tck_out, // Local clocks
  input wire logic [5:0] lp_tdo_out, // Data into chains
  input wire logic [5:0] lp_oe, // Drive enables
  output logic [5:0] lp_tdi_in // Data back from chains
);
  for (genvar g = 0; g < 6; g++)
  begin : g_ch
    logic bit_ff = 1'b0;
    // One-bit chain clocked only by the forwarded clock
    always @(posedge lp_tck_out[g]) bit_ff <= lp_tdo_out[g];
    // Undriven chain input sits on its pull-up
    assign lp_tdi_in[g] = lp_oe[g] ? bit_ff : 1'b1;
  end
endmodule // msm_chain_model

// ---- testbench.sv ----
// Self-checking bench for the scan chain multiplexer
`timescale 1ns/1ns
`include "msm_params.svh"
module testbench;
  typedef struct {logic [7:0] a; logic [7:0] s; logic m; logic e;} msm_row_t;
  logic mclk = 0, sys_rst = 1, m_tck = 0, m_tms = 1, m_tdi = 1, m_trst_n = 1, tdo_q, oe_q, s;
  logic [7:0] slot_id = 8'h00;
  logic slot_address_mask_in = 0, master_port_select = 0, local_oe_n = 0;
  logic idle_local_reset_level = 1, idle_local_reset_level_port6 = 0;
  logic backplane_reset_disregard = 0;
  logic addressed_or_stitch_select = 0, passthrough_strap = 0;
  logic [6:0] stitch_port_include = 7'h00;
  logic [31:0] o;
  int fails = 0, cmp_count = 0;
  logic [1:0] bp_tck_in, bp_tck_out, bp_tck_oe, bp_tms_in, bp_tms_out, bp_tms_oe, bp_tdi_in;
  logic [1:0] bp_tdo_out, bp_tdo_oe, bp_trst_n_in, bp_trst_n_out, bp_trst_oe, bp_pass_y_oe;
  logic [1:0] lp1_pass_y;
  logic [3:0] bp_pass_y;
  logic [4:0] hiz_notify_out;
  logic [5:0] lp_tck_out, lp_tms_out, lp_tdo_out, lp_tdi_in, lp_trst_n_out, lp_oe;
  logic lp1_pass_y_oe;
  wire ms = master_port_select;
  msm_row_t rows [8] = '{'{8'h21, 8'h21, 0, 1}, '{8'h21, 8'h22, 0, 0}, '{8'hFF, 8'h35, 0, 1},
    '{8'hF9, 8'h11, 0, 1}, '{8'hF9, 8'h12, 0, 0}, '{8'h00, 8'h00, 0, 0},
    '{8'h20, 8'h23, 1, 1}, '{8'h20, 8'h27, 1, 0}};
  // Master pin from the bench, slave pin from the design or its idle level
  function automatic logic pin(input logic m, input logic is_m, input logic oe, input logic d,
    input logic idle);
    return is_m ? m : (oe ? d : idle);
  endfunction
  // No pull-up on clock pins, so a released one toggles
  assign bp_tck_in = {pin(m_tck, ms, bp_tck_oe[1], bp_tck_out[1], mclk),
    pin(m_tck, !ms, bp_tck_oe[0], bp_tck_out[0], mclk)};
  assign bp_tms_in = {pin(m_tms, ms, bp_tms_oe[1], bp_tms_out[1], 1'b1),
    pin(m_tms, !ms, bp_tms_oe[0], bp_tms_out[0], 1'b1)};
  assign bp_trst_n_in = {pin(m_trst_n, ms, bp_trst_oe[1], bp_trst_n_out[1], 1'b1),
    pin(m_trst_n, !ms, bp_trst_oe[0], bp_trst_n_out[0], 1'b1)};
  assign bp_tdi_in = {pin(m_tdi, ms, 1'b0, 1'b0, 1'b1), pin(m_tdi, !ms, 1'b0, 1'b0, 1'b1)};
  msm_mux msm_mux_i (.mclk, .sys_rst, .bp_tck_in, .bp_tck_out, .bp_tck_oe, .bp_tms_in,
    .bp_tms_out, .bp_tms_oe, .bp_tdi_in, .bp_tdo_out, .bp_tdo_oe, .bp_trst_n_in, .bp_trst_n_out,
    .bp_trst_oe, .bp_pass_a(4'h5), .bp_pass_y, .bp_pass_y_oe, .lp_tck_out, .lp_tms_out,
    .lp_tdo_out, .lp_tdi_in, .lp_trst_n_out, .lp_oe, .lp1_pass_a(2'h2), .lp1_pass_y,
    .lp1_pass_y_oe, .hiz_notify_out, .slot_id, .slot_address_mask_in, .master_port_select,
    .addressed_or_stitch_select, .stitch_port_include, .passthrough_strap,
    .idle_local_reset_level, .idle_local_reset_level_port6, .backplane_reset_disregard,
    .local_oe_n);
  msm_chain_model msm_chain_model_i (.lp_tck_out, .lp_tdo_out, .lp_oe, .lp_tdi_in);
  always #2 mclk = ~mclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait8();
    repeat (8) @(posedge mclk);
    #1;
  endtask
  // One test clock period, entered just after an mclk edge
  task automatic tck(input logic t, input logic d);
    m_tms = t;
    m_tdi = d;
    m_tck = 1'b0;
    repeat (15) @(posedge mclk);
    #1 tdo_q = bp_tdo_out[0];
    oe_q = bp_tdo_oe[0];
    m_tck = 1'b1;
    repeat (16) @(posedge mclk);
    #1;
  endtask
  // From Run-Test/Idle through one IR or DR scan and back
  task automatic scan(input logic ir, input logic [31:0] v, input int n, output logic sel);
    o = '0;
    sel = 1'b0;
    tck(1, 0);
    if (ir) tck(1, 0);
    tck(0, 0);
    tck(0, 0);
    for (int i = 0; i < n; i++)
    begin
      tck(i == n - 1, v[i]);
      o[i] = tdo_q;
      sel |= oe_q;
    end
    tck(1, 0);
    tck(0, 0);
  endtask
  task automatic test_reset();
    m_trst_n = 1'b0;
    wait8();
    m_trst_n = 1'b1;
    wait8();
    tck(0, 0);
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    #1 chk("hiz in reset", 5'h1F, hiz_notify_out);
    chk("local resets", 6'h00, lp_trst_n_out);
    sys_rst = 1'b0;
    wait8();
    chk("idle resets", 6'h1F, lp_trst_n_out);
    chk("tlr park tms", 6'h3F, lp_tms_out);
    chk("pass off", 3'h0, {bp_pass_y_oe, lp1_pass_y_oe});
    m_trst_n = 1'b0;
    wait8();
    chk("gated resets", 6'h00, lp_trst_n_out);
    backplane_reset_disregard = 1'b1;
    wait8();
    chk("disregard", 6'h1F, lp_trst_n_out);
    m_trst_n = 1'b1;
    backplane_reset_disregard = 1'b0;
    $display("test local resets done");
    local_oe_n = 1'b1;
    wait8();
    chk("local oe", 6'h00, lp_oe);
    chk("hiz ports", 3'h7, hiz_notify_out[4:2]);
    chk("slave tck oe", 1'b0, bp_tck_oe[1]);
    local_oe_n = 1'b0;
    wait8();
    chk("slave tck on", 1'b1, bp_tck_oe[1]);
    chk("master tdo hiz", 1'b1, hiz_notify_out[0]);
    master_port_select = 1'b1;
    wait8();
    chk("b0 as slave", 2'b01, bp_tck_oe);
    master_port_select = 1'b0;
    wait8();
    chk("b0 as master", 2'b10, bp_tck_oe);
    $display("test ports done");
    foreach (rows[r])
    begin
      slot_id = rows[r].s;
      slot_address_mask_in = rows[r].m;
      test_reset();
      scan(1, rows[r].a, 8, s);
      scan(1, `MSM_OP_BYPASS, 8, s);
      chk("selected", rows[r].e, s);
      if (rows[r].e) chk("ir capture", `MSM_IR_CAP, o[7:0]);
    end
    $display("test address table done");
    slot_id = 8'h21;
    slot_address_mask_in = 1'b0;
    test_reset();
    scan(1, `MSM_ADDR_INTG, 8, s);
    scan(1, `MSM_OP_BYPASS, 8, s);
    chk("interrogate", 9'h121, {s, o[7:0]});
    test_reset();
    scan(1, 8'h21, 8, s);
    scan(1, `MSM_OP_BYPASS, 8, s);
    scan(0, 8'hA5, 8, s);
    chk("bypass data", 7'h25, o[7:1]);
    scan(1, `MSM_OP_MODE0, 8, s);
    scan(0, 32'h0000_0102, 9, s);
    scan(1, `MSM_OP_UNPARK, 8, s);
    scan(1, `MSM_OP_PARK, 8, s);
    m_tms = 1'b1;
    wait8();
    chk("unparked tms", 6'h01, lp_tms_out);
    scan(1, `MSM_OP_BYPASS, 8, s);
    m_tms = 1'b1;
    wait8();
    chk("parked tms", 6'h00, lp_tms_out);
    sys_rst = 1'b1;
    wait8();
    chk("hiz mid reset", 5'h1F, hiz_notify_out);
    sys_rst = 1'b0;
    wait8();
    tck(0, 0);
    scan(1, `MSM_OP_BYPASS, 8, s);
    chk("deselected", 1'b0, s);
    $display("test bypass and reset done");
    addressed_or_stitch_select = 1'b1;
    stitch_port_include = 7'h02;
    test_reset();
    scan(0, 32'h0000_00A5, 8, s);
    chk("stitch data", 7'h65, {s, o[7:2]});
    chk("pass to master", 2'h2, bp_pass_y[1:0]);
    chk("pass to port", 2'h1, lp1_pass_y);
    chk("pass enables", 3'h3, {bp_pass_y_oe, lp1_pass_y_oe});
    passthrough_strap = 1'b1;
    sys_rst = 1'b1;
    wait8();
    sys_rst = 1'b0;
    wait8();
    tck(0, 0);
    scan(0, 32'h0000_00A5, 8, s);
    chk("transparent data", 8'hA5, {s, o[7:1]});
    $display("test stitch done");
    report_and_stop();
  end
  initial
  begin
    repeat (90000) @(posedge mclk);
    fails++;
    report_and_stop();
  end
endmodule // testbench
